// *** bench/cspc_clock_ctrl_sva.sv ***
// assertions on the ports of the clock source and pll control block
module cspc_clock_ctrl_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic halt_mode,
  input wire logic ctrl_write,
  input wire logic [1:0] pwm_divide_field_wdata,
  input wire logic pwm_timer_run,
  input wire logic pwm_timer_mode_bit,
  input wire logic pwm_timer_overflow,
  input wire logic ref_source_reg,
  input wire logic oscillator_run,
  input wire logic multiplier_enable,
  input wire logic pll_locked,
  input wire logic pwm_clock_select,
  input wire logic fast_instruction_mode,
  input wire logic [1:0] pwm_divide_field,
  input wire logic [1:0] pwm_divide_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // timer mode bit counts as running for the interlocks
  wire logic busy = pwm_timer_run || pwm_timer_mode_bit;
  sequence s_halted;
    halt_mode ##1 halt_mode;
  endsequence
  property p_src_hold;
    $past(nrst) && $past(nrst, 2) |-> $stable(ref_source_reg);
  endproperty
  property p_osc_halt;
    s_halted |-> !oscillator_run;
  endproperty
  property p_lock_start;
    $rose(multiplier_enable) |-> !pll_locked;
  endproperty
  property p_en_lock;
    ctrl_write && busy |=> $stable(multiplier_enable);
  endproperty
  property p_sel_off;
    ctrl_write && !busy && !multiplier_enable |=> !pwm_clock_select;
  endproperty
  property p_fast_off;
    ctrl_write && !multiplier_enable |=> !fast_instruction_mode;
  endproperty
  property p_fs_read;
    ctrl_write |=> pwm_divide_field == $past(pwm_divide_field_wdata);
  endproperty
  property p_fs_hold;
    pwm_timer_run && !pwm_timer_overflow |=> $stable(pwm_divide_active);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source select moved");
  a_osc_halt: assert property (p_osc_halt) else $error("oscillator runs in halt");
  a_lock_start: assert property (p_lock_start) else $error("locked at enable");
  a_en_lock: assert property (p_en_lock) else $error("enable changed while busy");
  a_sel_off: assert property (p_sel_off) else $error("pwm select set with pll off");
  a_fast_off: assert property (p_fast_off) else $error("fast mode set with pll off");
  a_fs_read: assert property (p_fs_read) else $error("divide readback wrong");
  a_fs_hold: assert property (p_fs_hold) else $error("divide changed mid cycle");
endmodule // cspc_clock_ctrl_sva

bind cspc_clock_ctrl cspc_clock_ctrl_sva u_sva (.*);

// *** bench/cspc_timer_model.sv ***
// behavioural pwm timer counting the generated pwm clock
module cspc_timer_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pwm_clock_output,
  input wire logic start,
  output logic pwm_timer_run,
  output logic pwm_timer_mode_bit,
  output logic pwm_timer_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_reg;
  // ==========================================================
  // counter
  // held in pwm mode: mode bit tied low
  assign pwm_timer_mode_bit = 1'b0;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwm_timer_run <= 1'b0;
      cnt_reg <= 6'h00;
      pwm_timer_overflow <= 1'b0;
    end
    else
    begin
      pwm_timer_run <= start;
      pwm_timer_overflow <= pwm_timer_run && pwm_clock_output && cnt_reg == 6'h3f;
      if (pwm_timer_run && pwm_clock_output)
        cnt_reg <= cnt_reg + 6'h01;
    end
  end
endmodule // cspc_timer_model

// *** bench/tb.sv ***
// self-checking bench for the clock source and pll control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, nrst = 1'b0, ref_source_select = 1'b0, halt_mode = 1'b0, external_clock_pin = 1'b0;
  logic ref_halve_enable = 1'b0, ctrl_write = 1'b0, multiplier_enable_wdata = 1'b0, start = 1'b0;
  logic pwm_clock_select_wdata = 1'b0, fast_instruction_mode_wdata = 1'b0;
  logic [1:0] pwm_divide_field_wdata = 2'h0, pwm_divide_field, pwm_divide_active;
  logic pwm_timer_run, pwm_timer_mode_bit, pwm_timer_overflow, ref_source_reg, oscillator_run, multiplier_enable;
  logic pll_locked, pwm_clock_select, fast_instruction_mode, reference_clock, pll_reference_clock;
  logic instruction_clock, fast_clock_output, pwm_clock_output;
  logic [8:0] c_r, c_pr, c_i, c_f, c_p;
  int fail_count = 0, n_tests = 0, cyc = 0;
  cspc_clock_ctrl dut (.*);
  cspc_timer_model u_timer (.*);
  always #25 sys_clk = ~sys_clk;
  // free pin clock, eight system cycles a period
  always #200 external_clock_pin = ~external_clock_pin;
  // ==========================================================
  // tasks
  task automatic chk(input logic [8:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic me, sel, fm, input logic [1:0] fs);
    @(posedge sys_clk);
    #5;
    ctrl_write = 1'b1;
    multiplier_enable_wdata = me;
    pwm_clock_select_wdata = sel;
    fast_instruction_mode_wdata = fm;
    pwm_divide_field_wdata = fs;
    @(posedge sys_clk);
    #5;
    ctrl_write = 1'b0;
  endtask
  // settle the muxes, then count every enable over 256 cycles
  task automatic cnt;
    repeat (16) @(posedge sys_clk);
    {c_r, c_pr, c_i, c_f, c_p} = '0;
    repeat (256)
    begin
      @(posedge sys_clk);
      #5;
      c_r += {8'h00, reference_clock};
      c_pr += {8'h00, pll_reference_clock};
      c_i += {8'h00, instruction_clock};
      c_f += {8'h00, fast_clock_output};
      c_p += {8'h00, pwm_clock_output};
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test;
    end
  end
  // ==========================================================
  // tests
  initial
  begin
    repeat (20) @(posedge sys_clk);
    #5 nrst = 1'b1;
    halt_mode = 1'b1;
    cnt;
    chk(oscillator_run, 9'h0);
    chk(c_r, 9'h0);
    halt_mode = 1'b0;
    ref_source_select = 1'b1;
    cnt;
    chk(oscillator_run, 9'h1);
    chk(ref_source_reg, 9'h0);
    chk(c_r, 9'h80);
    chk(c_pr, c_r);
    chk(c_i, c_r >> 1);
    ref_halve_enable = 1'b1;
    cnt;
    chk(c_pr, c_r >> 1);
    ref_halve_enable = 1'b0;
    $display("test reference done");
    wr(1'b0, 1'b1, 1'b1, 2'h0);
    chk(pwm_clock_select, 9'h0);
    chk(fast_instruction_mode, 9'h0);
    wr(1'b1, 1'b0, 1'b0, 2'h0);
    chk(multiplier_enable, 9'h1);
    chk(pll_locked, 9'h0);
    repeat (cspc_pkg::LOCK_CYCLES + 10) @(posedge sys_clk);
    chk(pll_locked, 9'h1);
    for (int k = 0; k < 4; k++)
    begin
      wr(1'b1, 1'b1, 1'b1, k[1:0]);
      chk(pwm_clock_select, 9'h1);
      chk(pwm_divide_active, k[8:0]);
      cnt;
      chk(c_f, 9'h20);
      chk(c_p, 9'h20 << k);
      chk(c_i, c_f);
    end
    wr(1'b1, 1'b1, 1'b0, 2'h3);
    cnt;
    chk(c_i, c_r >> 1);
    $display("test multiplier done");
    #0 start = 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(1'b0, 1'b0, 1'b0, 2'h1);
    chk(multiplier_enable, 9'h1);
    chk(pwm_clock_select, 9'h1);
    chk(pwm_divide_field, 9'h1);
    chk(pwm_divide_active, 9'h3);
    for (int k = 0; k < 2000 && pwm_timer_overflow !== 1'b1; k++)
      #50;
    @(posedge sys_clk);
    #5;
    chk(pwm_divide_active, 9'h1);
    start = 1'b0;
    repeat (3) @(posedge sys_clk);
    // shut down: selects first, enable in a later write
    wr(1'b1, 1'b0, 1'b0, 2'h1);
    wr(1'b0, 1'b0, 1'b0, 2'h1);
    chk(multiplier_enable, 9'h0);
    $display("test timer done");
    nrst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #5 nrst = 1'b1;
    cnt;
    chk(ref_source_reg, 9'h1);
    chk(c_r, 9'h20);
    chk(oscillator_run, 9'h0);
    $display("test external done");
    stop_test;
  end
endmodule // tb

// *** rtl/cspc_clock_ctrl.sv ***
// clock source selection, multiplier model and clock enable generation
module cspc_clock_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ref_source_select,
  input wire logic halt_mode,
  input wire logic external_clock_pin,
  input wire logic ref_halve_enable,
  input wire logic ctrl_write,
  input wire logic multiplier_enable_wdata,
  input wire logic pwm_clock_select_wdata,
  input wire logic fast_instruction_mode_wdata,
  input wire logic [1:0] pwm_divide_field_wdata,
  input wire logic pwm_timer_run,
  input wire logic pwm_timer_mode_bit,
  input wire logic pwm_timer_overflow,
  output logic ref_source_reg,
  output logic oscillator_run,
  output logic multiplier_enable,
  output logic pll_locked,
  output logic pwm_clock_select,
  output logic fast_instruction_mode,
  output logic [1:0] pwm_divide_field,
  output logic [1:0] pwm_divide_active,
  output logic reference_clock,
  output logic pll_reference_clock,
  output logic instruction_clock,
  output logic fast_clock_output,
  output logic pwm_clock_output
);
  // ==========================================================
  // declarations
  localparam int REF_DIV_W_L = cspc_pkg::REF_DIV_W;
  logic load_done_reg;
  logic ext_sync;
  logic ext_prev_reg;
  logic osc_cnt_reg;
  logic ref_en;
  logic ref_half_reg;
  logic pll_ref_en;
  logic iclk_slow_reg;
  logic [REF_DIV_W_L-1:0] mult_cnt_reg;
  logic pll_en;
  logic [cspc_pkg::LOCK_W-1:0] lock_cnt_reg;
  logic fast_en;
  logic pwm_en;
  logic pwm_src_reg;
  logic iclk_src_reg;
  logic timer_busy;
  logic iclk_en;

  // mode bit high also counts as running: the safer reading of the interlock
  assign timer_busy = pwm_timer_run | pwm_timer_mode_bit;

  function automatic logic [1:0] fs_log2(input logic [1:0] fs);
    fs_log2 = 2'h3 - fs;
  endfunction

  // ==========================================================
  // reference source, latched once after reset release
  // load at reset sequence
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      load_done_reg <= 1'b0;
      ref_source_reg <= cspc_pkg::SRC_INTERNAL;
    end
    else if (!load_done_reg)
    begin
      load_done_reg <= 1'b1;
      ref_source_reg <= ref_source_select;
    end
  end

  // held off until the source is latched, as in the reset sequence
  // oscillator gating
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      oscillator_run <= 1'b0;
    else
      oscillator_run <= load_done_reg & ~halt_mode & (ref_source_reg == cspc_pkg::SRC_INTERNAL);
  end

  cspc_sync2 u_ext_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(external_clock_pin),
    .dout(ext_sync)
  );

  // internal oscillator modelled as sys_clk divided by two
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_cnt_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      osc_cnt_reg <= oscillator_run ? ~osc_cnt_reg : 1'b0;
      ext_prev_reg <= ext_sync;
    end
  end

  assign ref_en = (ref_source_reg == cspc_pkg::SRC_EXTERNAL) ? (ext_sync & ~ext_prev_reg)
                                                            : (oscillator_run & osc_cnt_reg);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_half_reg <= 1'b0;
      iclk_slow_reg <= 1'b0;
      reference_clock <= 1'b0;
      pll_reference_clock <= 1'b0;
    end
    else
    begin
      if (ref_en)
        ref_half_reg <= ~ref_half_reg;
      reference_clock <= ref_en;
      pll_reference_clock <= ref_halve_enable ? (ref_en & ref_half_reg) : ref_en;
      iclk_slow_reg <= ref_en & ref_half_reg;
    end
  end
  assign pll_ref_en = pll_reference_clock;

  // ==========================================================
  // control bits with write interlocks
  // enable frozen while timer runs
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      multiplier_enable <= 1'b0;
    else if (ctrl_write && !timer_busy)
      multiplier_enable <= multiplier_enable_wdata;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pwm_clock_select <= 1'b0;
    else if (ctrl_write && !timer_busy)
      pwm_clock_select <= pwm_clock_select_wdata & multiplier_enable;
  end

  // interlock reads the enable as it stands before this write
  // fast mode forced low
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      fast_instruction_mode <= 1'b0;
    else if (ctrl_write)
      fast_instruction_mode <= fast_instruction_mode_wdata & multiplier_enable;
  end

  // a write in the overflow cycle already governs the next pwm cycle
  // readback of written field
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwm_divide_field <= cspc_pkg::FS_RESET;
      pwm_divide_active <= cspc_pkg::FS_RESET;
    end
    else
    begin
      if (ctrl_write)
        pwm_divide_field <= pwm_divide_field_wdata;
      if (!pwm_timer_run || pwm_timer_overflow)
        pwm_divide_active <= ctrl_write ? pwm_divide_field_wdata : pwm_divide_field;
    end
  end

  // ==========================================================
  // multiplier: 32 output edges per reference edge
  // saturates at the system rate, every cycle then carries a pulse
  // multiply by 32
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      mult_cnt_reg <= '0;
    else if (!multiplier_enable)
      mult_cnt_reg <= '0;
    else if (pll_ref_en)
      mult_cnt_reg <= REF_DIV_W_L'(cspc_pkg::PLL_MULT - 1);
    else if (mult_cnt_reg != '0)
      mult_cnt_reg <= mult_cnt_reg - 1'b1;
  end
  assign pll_en = multiplier_enable & (pll_ref_en | (mult_cnt_reg != '0));

  // lock phase count
  // lock time is a fixed count; the flag only informs software
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      lock_cnt_reg <= '0;
    else if (!multiplier_enable)
      lock_cnt_reg <= '0;
    else if (lock_cnt_reg != cspc_pkg::LOCK_W'(cspc_pkg::LOCK_CYCLES))
      lock_cnt_reg <= lock_cnt_reg + 1'b1;
  end

  // flag drops with the enable, so a re-enable restarts the wait
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pll_locked <= 1'b0;
    else
      pll_locked <= multiplier_enable && (lock_cnt_reg == cspc_pkg::LOCK_W'(cspc_pkg::LOCK_CYCLES));
  end

  cspc_edge_div u_fast_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .en_in(pll_en),
    .log2_div(fs_log2(cspc_pkg::FS_DIV8)),
    .en_out(fast_en)
  );

  cspc_edge_div u_pwm_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .en_in(pll_en),
    .log2_div(fs_log2(pwm_divide_active)),
    .en_out(pwm_en)
  );

  // ==========================================================
  // glitch-free source switching
  // instruction stream after its own switch, shared by the pwm route
  assign iclk_en = iclk_src_reg ? fast_en : iclk_slow_reg;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      iclk_src_reg <= 1'b0;
      pwm_src_reg <= 1'b0;
    end
    else
    begin
      if (!iclk_slow_reg && !fast_en)
        iclk_src_reg <= fast_instruction_mode;
      if (!pwm_en && !iclk_en)
        pwm_src_reg <= pwm_clock_select;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      instruction_clock <= 1'b0;
      fast_clock_output <= 1'b0;
      pwm_clock_output <= 1'b0;
    end
    else
    begin
      instruction_clock <= iclk_en;
      fast_clock_output <= fast_en;
      pwm_clock_output <= pwm_src_reg ? pwm_en : iclk_en;
    end
  end
endmodule // cspc_clock_ctrl

// *** rtl/cspc_edge_div.sv ***
// divider of an enable stream by a power of two, one pulse per period
module cspc_edge_div (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic en_in,
  input wire logic [1:0] log2_div,
  output logic en_out
);
  logic [2:0] cnt_reg;
  logic [2:0] mask;

  always_comb
  begin
    mask = 3'h0;
    unique case (log2_div)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
  end

  // pulse on the last input enable of each period; a mask change applies from the next input enable, mid period
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= 3'h0;
      en_out <= 1'b0;
    end
    else
    begin
      en_out <= 1'b0;
      if (en_in)
      begin
        if ((cnt_reg & mask) == mask)
        begin
          cnt_reg <= 3'h0;
          en_out <= 1'b1;
        end
        else
        begin
          cnt_reg <= cnt_reg + 3'h1;
        end
      end
    end
  end
endmodule // cspc_edge_div

// *** rtl/cspc_pkg.sv ***
// shared constants for the clock source and pll control block
package cspc_pkg;
  // ==========================================================
  // divide field encodings and reset values
  localparam logic [1:0] FS_DIV8 = 2'h0;
  localparam logic [1:0] FS_DIV4 = 2'h1;
  localparam logic [1:0] FS_DIV2 = 2'h2;
  localparam logic [1:0] FS_DIV1 = 2'h3;
  localparam logic [1:0] FS_RESET = 2'h0;
  localparam logic SRC_INTERNAL = 1'b0;
  localparam logic SRC_EXTERNAL = 1'b1;
  // ==========================================================
  // multiplier model: one pll output cycle per sys_clk enable
  localparam int PLL_MULT = 32;
  localparam int PLL_DIV_W = 3;
  localparam int REF_DIV_W = 5;
  // ==========================================================
  // lock time model
  localparam int LOCK_TIME_US = 100;
  localparam int CLK_MHZ = 20;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  localparam int LOCK_W = 12;
endpackage : cspc_pkg

// *** rtl/cspc_sync2.sv ***
// two flip-flop synchroniser for a pin level
module cspc_sync2 (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic meta_reg;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule // cspc_sync2
